// ### rtl/irq_ctl.sv
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "irq_ctl_map.svh"
module irq_ctl import irq_ctl_pkg::*; #(
    parameter int UNIT_10MS_CYC = (10000000 / `CLK_PERIOD_NS), // Cycles per 10 ms
    parameter int UNIT_1MS_CYC = (1000000 / `CLK_PERIOD_NS), // Cycles per 1 ms
    parameter int UNIT_100US_CYC = (`UNIT_100US_NS / `CLK_PERIOD_NS) // Cycles per 0.1 ms
) (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // External interrupt pins
    input wire logic [31:0] io_irq_pin,
    input wire logic [7:0] in_irq_pin,
    // Task requests and sync operation strap
    input wire logic sync_mode,
    output logic [31:0] io_task_req,
    output logic [7:0] in_task_req,
    output logic [1:0] sched_task_req
);
    // Bus address phase capture
    logic wr_q; // Pending write
    logic [7:0] addr_q; // Captured address
    logic [31:0] rdata_q; // Read data register
    logic [1:0] pad_unused; // Spare bits of hsize
    // Software registers
    logic [7:0] sel_q; // Operation selector
    logic [15:0] data_q; // Control word
    logic [15:0] result_q; // Read-mask result
    logic err_q; // Instruction error
    logic [3:0] cfg_q; // Time unit, eight-input, small variant
    // Interrupt state
    logic [31:0] io_mask_q, io_edge_q, io_pend_q;
    logic [7:0] in_mask_q, in_edge_q, in_pend_q;
    logic [31:0] io_s1_q, io_s2_q, io_s3_q; // Pin synchroniser and history
    logic [7:0] in_s1_q, in_s2_q, in_s3_q;
    // Task timing
    logic [7:0] cur_task_q; // Task being timed
    logic task_busy_q; // A task is timed
    logic [31:0] task_time_q; // Running time of current task
    logic [31:0] max_time_q; // Longest time seen
    logic [7:0] max_task_q; // Task of longest time
    // Time unit prescaler
    logic [31:0] pre_q;
    logic tick_q;
    // Decoded one-cycle operations
    logic do_set, do_read, do_done;
    logic [31:0] io_mask_wr, io_edge_wr;
    logic [7:0] in_mask_wr, in_edge_wr;
    logic [31:0] io_ctl; // Control word spread over the I/O lanes
    logic [3:0] sel_in_idx, sel_edge_idx; // Input and edge index of the selector
    logic [31:0] io_rise, io_fall;
    logic [7:0] in_rise, in_fall;

    sched_timer_if st0 ();
    sched_timer_if st1 ();

    // Selector in a built-in input range, gives the input index
    function automatic logic [3:0] in_index(input logic [7:0] s);
        if (s >= SEL_IN0 && s <= SEL_IN3) return {1'b0, 3'(s - SEL_IN0)};
        if (s >= SEL_PM0 && s <= SEL_PM7) return {1'b0, 3'(s - SEL_PM0)};
        return 4'h8;
    endfunction : in_index

    function automatic logic [3:0] edge_index(input logic [7:0] s);
        if (s >= SEL_EDG0 && s <= SEL_EDG3) return {1'b0, 3'(s - SEL_EDG0)};
        if (s >= SEL_PE0 && s <= SEL_PE7) return {1'b0, 3'(s - SEL_PE0)};
        return 4'h8;
    endfunction : edge_index

    // Write mask of I/O bits covered by a unit selector
    function automatic logic [31:0] io_lanes(input logic [7:0] s, input logic eight);
        logic [31:0] m;
        m = 32'h0000_0000;
        if (!eight && s <= SEL_IO1) m = 32'h0000_FFFF << (s[0] * 16);
        if (eight && s <= SEL_IO3) m = 32'h0000_00FF << (s[1:0] * 8);
        return m;
    endfunction : io_lanes

    // Eight-input units take control bits 7:0 each, sixteen-input units bits 15:0
    function automatic logic [31:0] ctl_spread(input logic [15:0] d, input logic eight);
        return eight ? {4{d[7:0]}} : {2{d}};
    endfunction : ctl_spread

    assign io_ctl = ctl_spread(data_q, cfg_q[`CFG_EIGHT_BIT]);
    assign sel_in_idx = in_index(sel_q);
    assign sel_edge_idx = edge_index(sel_q);
    assign pad_unused = hsize[1:0];
    assign do_set = ce && wr_q && addr_q == `REG_OP_CMD && hwdata[`CMD_SET_BIT];
    assign do_read = ce && wr_q && addr_q == `REG_OP_CMD && hwdata[`CMD_READ_BIT];
    assign do_done = ce && wr_q && addr_q == `REG_TASK_DONE;

    // Compute mask and edge write selects for one set operation
    always_comb begin
        logic [31:0] lanes;
        logic [3:0] ii;
        logic [3:0] ei;
        lanes = io_lanes(sel_q, cfg_q[`CFG_EIGHT_BIT]);
        ii = in_index(sel_q);
        ei = edge_index(sel_q);
        io_mask_wr = do_set ? lanes : 32'h0000_0000;
        io_edge_wr = (do_set && !cfg_q[`CFG_EIGHT_BIT] && (sel_q == SEL_IO2 || sel_q == SEL_IO3)) ?
                     (32'h0000_FFFF << (sel_q[0] * 16)) : 32'h0000_0000;
        in_mask_wr = (do_set && !ii[3]) ? (8'h01 << ii[2:0]) : 8'h00;
        in_edge_wr = (do_set && !ei[3]) ? (8'h01 << ei[2:0]) : 8'h00;
    end

    // AHB-Lite slave: zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else if (ce) begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            if (hsel && hready && htrans[1]) begin
                addr_q <= haddr;
            end
        end
    end

    // Read data, registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (ce && hsel && hready && htrans[1] && !hwrite) begin
            case (haddr)
                `REG_OP_SEL: rdata_q <= {24'h000000, sel_q};
                `REG_OP_DATA: rdata_q <= {16'h0000, data_q};
                `REG_RESULT: rdata_q <= {16'h0000, result_q};
                `REG_STATUS: rdata_q <= {30'h0, sync_mode, err_q};
                `REG_MAX_TIME: rdata_q <= max_time_q;
                `REG_MAX_TASK: rdata_q <= {24'h000000, max_task_q};
                `REG_UNIT_CFG: rdata_q <= {28'h0000000, cfg_q};
                `REG_PEND: rdata_q <= {in_pend_q, io_pend_q[23:0]};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end
    assign hrdata = rdata_q;

    // Software operand and configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_q <= 8'h00;
            data_q <= 16'h0000;
            cfg_q <= {2'b00, `UNIT_RESET};
        end else if (ce && wr_q) begin
            if (addr_q == `REG_OP_SEL) sel_q <= hwdata[7:0];
            if (addr_q == `REG_OP_DATA) data_q <= hwdata[15:0];
            if (addr_q == `REG_UNIT_CFG) cfg_q <= hwdata[3:0];
        end
    end

    // Instruction error: schedule selector set in sync mode, or timer 1 selector in the small variant
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_q <= 1'b0;
        end else if (do_set || do_read) begin
            err_q <= 1'b0;
            if (sync_mode && (sel_q == SEL_SCH0 || sel_q == SEL_SCH1)) err_q <= do_set;
            if (cfg_q[`CFG_SMALL_BIT] && (sel_q == SEL_SCH1 || sel_q == SEL_RST1)) err_q <= 1'b1;
        end
    end

    // Mask and edge settings: masked and rising at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_mask_q <= 32'hFFFF_FFFF;
            in_mask_q <= 8'hFF;
            io_edge_q <= 32'h0000_0000;
            in_edge_q <= 8'h00;
        end else if (ce) begin
            io_mask_q <= (io_mask_q & ~io_mask_wr) | (io_ctl & io_mask_wr);
            io_edge_q <= (io_edge_q & ~io_edge_wr) | ({2{data_q}} & io_edge_wr);
            in_mask_q <= (in_mask_q & ~in_mask_wr) | ({8{data_q[0]}} & in_mask_wr);
            in_edge_q <= (in_edge_q & ~in_edge_wr) | ({8{data_q[0]}} & in_edge_wr);
        end
    end

    // Two-stage pin synchroniser plus history stage for edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_s1_q <= 32'h0000_0000;
            io_s2_q <= 32'h0000_0000;
            io_s3_q <= 32'h0000_0000;
            in_s1_q <= 8'h00;
            in_s2_q <= 8'h00;
            in_s3_q <= 8'h00;
        end else if (ce) begin
            io_s1_q <= io_irq_pin;
            io_s2_q <= io_s1_q;
            io_s3_q <= io_s2_q;
            in_s1_q <= in_irq_pin;
            in_s2_q <= in_s1_q;
            in_s3_q <= in_s2_q;
        end
    end
    assign io_rise = io_s2_q & ~io_s3_q;
    assign io_fall = ~io_s2_q & io_s3_q;
    assign in_rise = in_s2_q & ~in_s3_q;
    assign in_fall = ~in_s2_q & in_s3_q;

    // Pending detections: cleared on enable or edge change, new edge wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_pend_q <= 32'h0000_0000;
            in_pend_q <= 8'h00;
        end else if (ce) begin
            io_pend_q <= ((io_pend_q & ~io_task_req) & ~(io_mask_wr & ~io_ctl) & ~io_edge_wr)
                       | ((io_edge_q & io_fall) | (~io_edge_q & io_rise));
            in_pend_q <= ((in_pend_q & ~in_task_req) & ~(in_mask_wr & ~{8{data_q[0]}}) & ~in_edge_wr)
                       | ((in_edge_q & in_fall) | (~in_edge_q & in_rise));
        end
    end

    // Task requests, one cycle each; I/O and input requests gated by the mask
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            io_task_req <= 32'h0000_0000;
            in_task_req <= 8'h00;
            sched_task_req <= 2'b00;
        end else if (ce) begin
            io_task_req <= io_pend_q & ~io_mask_q & ~io_task_req;
            in_task_req <= in_pend_q & ~in_mask_q & ~in_task_req;
            sched_task_req <= {st1.fire & ~cfg_q[`CFG_SMALL_BIT], st0.fire};
        end
    end

    // Read-mask result by selector
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            result_q <= 16'h0000;
        end else if (do_read) begin
            case (sel_q)
                SEL_IO0, SEL_IO1, SEL_IO2, SEL_IO3: begin
                    if (cfg_q[`CFG_EIGHT_BIT]) result_q <= {8'h00, io_mask_q[sel_q[1:0] * 8 +: 8]};
                    else result_q <= io_mask_q[sel_q[0] * 16 +: 16];
                end
                SEL_SCH0: result_q <= st0.set_value;
                SEL_SCH1: result_q <= st1.set_value;
                SEL_RST0: result_q <= st0.present;
                SEL_RST1: result_q <= st1.present;
                default: begin
                    if (!sel_in_idx[3]) result_q <= {15'h0000, in_mask_q[sel_in_idx[2:0]]};
                    else if (!sel_edge_idx[3]) result_q <= {15'h0000, in_edge_q[sel_edge_idx[2:0]]};
                    else result_q <= 16'h0000;
                end
            endcase
        end
    end

    // Time unit prescaler
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else if (ce) begin
            tick_q <= 1'b0;
            if (pre_q >= 32'((cfg_q[1:0] == `UNIT_1MS) ? UNIT_1MS_CYC :
                (cfg_q[1:0] == `UNIT_100US) ? UNIT_100US_CYC : UNIT_10MS_CYC) - 32'h1) begin
                pre_q <= 32'h0000_0000;
                tick_q <= 1'b1;
            end else begin
                pre_q <= pre_q + 32'h1;
            end
        end
    end

    // Timer commands from the set operation
    always_comb begin
        st0.tick = tick_q;
        st1.tick = tick_q;
        st0.interval = data_q;
        st1.interval = data_q;
        st0.load = do_set && sel_q == SEL_SCH0 && !sync_mode;
        st1.load = do_set && sel_q == SEL_SCH1 && !sync_mode && !cfg_q[`CFG_SMALL_BIT];
        st0.load_reset = do_set && sel_q == SEL_RST0;
        st1.load_reset = do_set && sel_q == SEL_RST1 && !cfg_q[`CFG_SMALL_BIT];
        st0.stop = 1'b0;
        st1.stop = 1'b0;
    end

    sched_timer u_t0 (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(st0));
    sched_timer u_t1 (.hclk(hclk), .hresetn(hresetn), .ce(ce), .t(st1));

    // Task processing time: start on a scheduled request, end on a done write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            task_busy_q <= 1'b0;
            cur_task_q <= 8'h00;
            task_time_q <= 32'h0000_0000;
            max_time_q <= 32'h0000_0000;
            max_task_q <= 8'h00;
        end else if (ce) begin
            if (task_busy_q) task_time_q <= task_time_q + 32'h1;
            if (do_done && task_busy_q) begin
                task_busy_q <= 1'b0;
                if (task_time_q > max_time_q) begin
                    max_time_q <= task_time_q;
                    max_task_q <= cur_task_q;
                end
            end else if (!task_busy_q && !do_done) begin
                if (sched_task_req[0]) begin
                    task_busy_q <= 1'b1;
                    cur_task_q <= `TASK_SCHED0;
                    task_time_q <= 32'h0000_0000;
                end else if (sched_task_req[1]) begin
                    task_busy_q <= 1'b1;
                    cur_task_q <= `TASK_SCHED1;
                    task_time_q <= 32'h0000_0000;
                end
            end
        end
    end
endmodule : irq_ctl

// ### rtl/irq_ctl_map.svh
`ifndef IRQ_CTL_MAP_SVH
`define IRQ_CTL_MAP_SVH
// Register byte offsets
`define REG_OP_SEL 8'h00
`define REG_OP_DATA 8'h04
`define REG_OP_CMD 8'h08
`define REG_RESULT 8'h0C
`define REG_STATUS 8'h10
`define REG_MAX_TIME 8'h14
`define REG_MAX_TASK 8'h18
`define REG_UNIT_CFG 8'h1C
`define REG_TASK_DONE 8'h20
`define REG_PEND 8'h24
// Command field bits
`define CMD_SET_BIT 0
`define CMD_READ_BIT 1
`define CMD_DONE_BIT 2
// Status fields
`define STAT_ERR_BIT 0
`define STAT_SYNC_BIT 1
// Unit cfg fields: time unit code bits 1:0, eight-input unit mode bit 2, small variant bit 3
`define CFG_UNIT_LSB 0
`define CFG_EIGHT_BIT 2
`define CFG_SMALL_BIT 3
// Time unit codes, reset is 10 ms
`define UNIT_10MS 2'h0
`define UNIT_1MS 2'h1
`define UNIT_100US 2'h2
`define UNIT_RESET 2'h0
// Time units in ns and the clock period
`define CLK_PERIOD_NS 4
`define UNIT_100US_NS 100000
// Task numbers
`define TASK_SCHED0 8'h02
`define TASK_SCHED1 8'h03
`define TASK_IO_BASE 8'h64
`define TASK_IN_BASE 8'h8C
`endif

// ### rtl/irq_ctl_pkg.sv
package irq_ctl_pkg;
    // Selector codes of the set and read mask operations
    typedef enum logic [7:0] {
        SEL_IO0 = 8'h00, SEL_IO1 = 8'h01, SEL_IO2 = 8'h02, SEL_IO3 = 8'h03,
        SEL_SCH0 = 8'h04, SEL_SCH1 = 8'h05,
        SEL_IN0 = 8'h06, SEL_IN3 = 8'h09,
        SEL_EDG0 = 8'h0A, SEL_EDG3 = 8'h0D,
        SEL_RST0 = 8'h0E, SEL_RST1 = 8'h0F,
        SEL_PM0 = 8'h64, SEL_PM7 = 8'h6B,
        SEL_PE0 = 8'h6E, SEL_PE7 = 8'h75
    } sel_t;
    // Bus slave states
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_DATA = 2'b01
    } bus_state_t;
endpackage : irq_ctl_pkg

// ### rtl/sched_timer_if.sv
`timescale 1ns/1ns
// Control and status between the controller and one scheduled timer
interface sched_timer_if;
    logic load; // Load interval and run, keep present value
    logic load_reset; // Load interval, zero present value, run
    logic stop; // Stop the timer
    logic [15:0] interval; // Interval in time units
    logic tick; // One time unit elapsed
    logic fire; // Interval reached, one-cycle pulse
    logic running; // Timer running
    logic [15:0] set_value; // Held interval
    logic [15:0] present; // Present value
    modport ctl (output load, load_reset, stop, interval, tick, input fire, running, set_value, present);
    modport tmr (input load, load_reset, stop, interval, tick, output fire, running, set_value, present);
endinterface : sched_timer_if

// ### rtl/sched_timer.sv
`timescale 1ns/1ns
// One scheduled-interrupt interval timer
module sched_timer (
    // Clock, reset, enable
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Control
    sched_timer_if.tmr t
);
    logic [15:0] set_q; // Interval
    logic [15:0] pv_q; // Present value
    logic run_q; // Running
    logic fire_q; // Fire pulse

    assign t.running = run_q;
    assign t.set_value = set_q;
    assign t.present = pv_q;
    assign t.fire = fire_q;

    // Run state: stopped at reset, zero interval stops
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_q <= 1'b0;
            set_q <= 16'h0000;
        end else if (ce) begin
            if (t.stop) begin
                run_q <= 1'b0;
            end else if (t.load || t.load_reset) begin
                set_q <= t.interval;
                run_q <= (t.interval != 16'h0000);
            end
        end
    end

    // Present value: kept on restart, zeroed on reset-start, wraps at interval
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pv_q <= 16'h0000;
            fire_q <= 1'b0;
        end else if (ce) begin
            fire_q <= 1'b0;
            if (t.load_reset) begin
                pv_q <= 16'h0000;
            end else if (run_q && t.tick && !t.load && !t.stop) begin
                // Retained value continues after a restart
                if (pv_q + 16'h0001 >= set_q) begin
                    pv_q <= 16'h0000;
                    fire_q <= 1'b1;
                end else begin
                    pv_q <= pv_q + 16'h0001;
                end
            end
        end
    end
endmodule : sched_timer

// ### bench/irq_ctl_asserts.sv
`timescale 1ns/1ns
// Port-level checks of the interrupt controller
module irq_ctl_asserts (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pins and task requests
    input wire logic [31:0] io_irq_pin,
    input wire logic [7:0] in_irq_pin,
    input wire logic [31:0] io_task_req,
    input wire logic [7:0] in_task_req,
    input wire logic [1:0] sched_task_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic pin0_q; // Last level of io line 0
    logic [3:0] since0_q; // Cycles since io line 0 moved, saturating
    logic rd_addr; // Read address phase taken
    assign rd_addr = hsel && hready && htrans[1] && !hwrite;
    // Age of the last change on io line 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin0_q <= 1'b0;
            since0_q <= 4'hF;
        end else begin
            pin0_q <= io_irq_pin[0];
            if (io_irq_pin[0] != pin0_q) begin
                since0_q <= 4'h0;
            end else if (since0_q != 4'hF) begin
                since0_q <= since0_q + 4'h1;
            end
        end
    end
    AST_QUIET_AFTER_RESET: assert property (!$past(hresetn) |-> io_task_req == 32'h0 && sched_task_req == 2'h0)
        else $error("Task request right after reset");
    AST_BUS_OKAY: assert property (hreadyout == 1'b1 && hresp == 1'b0)
        else $error("Slave not ready or not OKAY");
    AST_IO_ONE_CYCLE: assert property ((io_task_req & $past(io_task_req)) == 32'h0)
        else $error("IO task request longer than one cycle");
    AST_IN_ONE_CYCLE: assert property ((in_task_req & $past(in_task_req)) == 8'h0)
        else $error("Input task request longer than one cycle");
    AST_IO_CAUSE: assert property (io_task_req[0] |-> since0_q <= 4'hA)
        else $error("IO task request without a recent edge");
    AST_SCHED_ONE_CYCLE: assert property (sched_task_req[0] |=> !sched_task_req[0])
        else $error("Scheduled request longer than one cycle");
    AST_RDATA_HOLD: assert property (!$past(rd_addr) |-> $stable(hrdata))
        else $error("Read data moved without a read");
    AST_UNMAPPED_ZERO: assert property (rd_addr && haddr >= 8'h28 |=> hrdata == 32'h0)
        else $error("Unmapped read not zero");
    COV_IO: cover property (io_task_req[0]);
    COV_IN: cover property (in_task_req[0]);
    COV_SCHED: cover property (sched_task_req[0]);
endmodule : irq_ctl_asserts

bind irq_ctl irq_ctl_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .io_irq_pin(io_irq_pin), .in_irq_pin(in_irq_pin), .io_task_req(io_task_req), .in_task_req(in_task_req),
    .sched_task_req(sched_task_req));

// ### bench/irq_pin_source.sv
`timescale 1ns/1ns
// External interrupt lines, idle low
module irq_pin_source (
    // Clock
    input wire logic hclk,
    // Lines toward the controller
    output logic [31:0] io_irq_pin,
    output logic [7:0] in_irq_pin
);
    initial begin
        io_irq_pin = 32'h0;
        in_irq_pin = 8'h0;
    end
    // Moves one io line, held long enough to pass the synchroniser
    task automatic set_io(input int n, input logic v);
        @(posedge hclk);
        io_irq_pin[n] <= v;
        repeat (8) @(posedge hclk);
    endtask : set_io
    // Moves one built-in line, held the same way
    task automatic set_in(input int n, input logic v);
        @(posedge hclk);
        in_irq_pin[n] <= v;
        repeat (8) @(posedge hclk);
    endtask : set_in
endmodule : irq_pin_source

// ### bench/interrupt_mask_and_scheduled_timer_tb.sv
`timescale 1ns/1ns
`include "irq_ctl_map.svh"
module interrupt_mask_and_scheduled_timer_tb;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sync_mode;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [31:0] io_irq_pin, io_task_req;
    logic [7:0] in_irq_pin, in_task_req;
    logic [1:0] sched_task_req;
    logic [15:0] rv;
    int errors = 0, tests_run = 0, cyc = 0, io_cnt = 0, in_cnt = 0, sch_cnt = 0, t0, t1;
    int seed = 32'ha49f30eb;
    int mask_m[4] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF}; // Mask model, all masked at start
    assign hready = hreadyout;
    irq_ctl #(.UNIT_10MS_CYC(10), .UNIT_1MS_CYC(5), .UNIT_100US_CYC(2)) uut (.hclk(hclk), .hresetn(hresetn),
        .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .io_irq_pin(io_irq_pin),
        .in_irq_pin(in_irq_pin), .sync_mode(sync_mode), .io_task_req(io_task_req), .in_task_req(in_task_req),
        .sched_task_req(sched_task_req));
    irq_pin_source src (.hclk(hclk), .io_irq_pin(io_irq_pin), .in_irq_pin(in_irq_pin));
    // Clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // Request counters
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (io_task_req[0] === 1'b1) io_cnt <= io_cnt + 1;
        if (in_task_req[0] === 1'b1) in_cnt <= in_cnt + 1;
        if (sched_task_req[0] === 1'b1) sch_cnt <= sch_cnt + 1;
    end
    // Verdict
    task automatic finish_test();
        if (errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // Compare
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", name, exp, got);
            errors++;
        end
    endtask : check
    // One single AHB-Lite transfer
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        n = 0;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
        r = hrdata;
        if (n >= 100) begin
            errors++;
            $display("BAD bus expected ready seen none");
            finish_test();
        end
    endtask : xfer
    // Selector, control word, command
    task automatic op(input logic [7:0] sel, input logic [31:0] d, input logic [31:0] cmd);
        logic [31:0] r;
        xfer(1'b1, `REG_OP_SEL, {24'h0, sel}, r);
        xfer(1'b1, `REG_OP_DATA, d, r);
        xfer(1'b1, `REG_OP_CMD, cmd, r);
    endtask : op
    // Read-mask operation and its result
    task automatic read_mask(input logic [7:0] sel, output logic [31:0] r);
        op(sel, 32'h0, 32'h2);
        xfer(1'b0, `REG_RESULT, 32'h0, r);
    endtask : read_mask
    // Waits for the next scheduled request, bounded
    task automatic wait_sched(input int lim, output int t);
        int base, n;
        base = sch_cnt;
        n = 0;
        while (sch_cnt == base && n < lim) begin
            @(posedge hclk);
            n++;
        end
        t = cyc;
        if (n >= lim) begin
            errors++;
            $display("BAD sched expected pulse seen none");
            finish_test();
        end
    endtask : wait_sched
    // Hang guard
    initial begin
        repeat (50000) @(posedge hclk);
        errors++;
        $display("BAD run expected end seen timeout");
        finish_test();
    end
    // Main sequence
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, sync_mode} = 3'h0;
        haddr = 8'h00;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int u = 0; u < 2; u++) begin
            read_mask(u[7:0], rd);
            check("mask reset", 32'(mask_m[u]), rd);
        end
        rv = 16'($random(seed));
        op(8'h01, {16'h0, rv}, 32'h1);
        mask_m[1] = rv;
        read_mask(8'h01, rd);
        check("mask unit1", 32'(mask_m[1]), rd);
        xfer(1'b1, `REG_UNIT_CFG, 32'h4, rd);
        read_mask(8'h03, rd);
        check("mask eight", 32'(mask_m[1]) >> 8, rd);
        xfer(1'b1, `REG_UNIT_CFG, 32'h0, rd);
        src.set_io(0, 1'b1);
        src.set_io(0, 1'b0);
        op(8'h00, 32'hFFFE, 32'h1);
        mask_m[0] = 32'hFFFE;
        read_mask(8'h00, rd);
        check("mask unit0", 32'(mask_m[0]), rd);
        check("io stale", 32'h0, 32'(io_cnt));
        src.set_io(0, 1'b1);
        check("io rising", 32'h1, 32'(io_cnt));
        src.set_io(0, 1'b0);
        check("io falling", 32'h1, 32'(io_cnt));
        op(8'h0A, 32'h1, 32'h1);
        op(8'h06, 32'h0, 32'h1);
        read_mask(8'h06, rd);
        check("in code", 32'h0, rd);
        src.set_in(0, 1'b1);
        check("in rising", 32'h0, 32'(in_cnt));
        src.set_in(0, 1'b0);
        check("in falling", 32'h1, 32'(in_cnt));
        op(8'h64, 32'h1, 32'h1);
        src.set_in(0, 1'b1);
        src.set_in(0, 1'b0);
        check("in masked", 32'h1, 32'(in_cnt));
        xfer(1'b0, `REG_PEND, 32'h0, rd);
        check("in pending", 32'h1, {31'h0, rd[24]});
        op(8'h6E, 32'h0, 32'h1);
        xfer(1'b0, `REG_PEND, 32'h0, rd);
        check("edge clears", 32'h0, {31'h0, rd[24]});
        op(8'h0E, 32'h3, 32'h1); // reset-start, interval of 3 units, 30 cycles
        wait_sched(40, t0);
        wait_sched(40, t1);
        check("period", 32'd30, 32'(t1 - t0));
        op(8'h04, 32'h0, 32'h1);
        t0 = sch_cnt;
        repeat (100) @(posedge hclk);
        check("stopped", 32'(t0), 32'(sch_cnt));
        sync_mode <= 1'b1;
        op(8'h04, 32'h3, 32'h1);
        xfer(1'b0, `REG_STATUS, 32'h0, rd);
        check("sync error", 32'h1, {31'h0, rd[0]});
        repeat (80) @(posedge hclk);
        check("sync idle", 32'(t0), 32'(sch_cnt));
        sync_mode <= 1'b0;
        op(8'h04, 32'h3, 32'h1);
        wait_sched(31, t0);
        wait_sched(40, t1);
        check("restart period", 32'd30, 32'(t1 - t0));
        xfer(1'b1, `REG_TASK_DONE, 32'h0, rd);
        xfer(1'b0, `REG_MAX_TASK, 32'h0, rd);
        check("max task", {24'h0, `TASK_SCHED0}, rd);
        xfer(1'b0, `REG_MAX_TIME, 32'h0, rd);
        check("max time", 32'h1, {31'h0, rd != 32'h0});
        xfer(1'b1, `REG_UNIT_CFG, 32'h8, rd);
        op(8'h0F, 32'h3, 32'h1);
        xfer(1'b0, `REG_STATUS, 32'h0, rd);
        check("small variant", 32'h1, {31'h0, rd[0]});
        xfer(1'b0, 8'h3C, 32'h0, rd);
        check("unmapped", 32'h0, rd);
        finish_test();
    end
endmodule : interrupt_mask_and_scheduled_timer_tb
